// ---- rtl/irq_prio_cfg.svh ----
// register offsets, field positions and reset values of the irq block
`ifndef IRQ_PRIO_CFG_SVH
`define IRQ_PRIO_CFG_SVH

// byte offsets on the register bus
`define OFS_IE_MAIN      8'h00
`define OFS_IE_EXT       8'h04
`define OFS_PRIO_A       8'h08
`define OFS_PRIO_B       8'h0c
`define OFS_PRIO_C       8'h10
`define OFS_PRIO_D       8'h14
`define OFS_PRIO_E       8'h18
`define OFS_STATUS       8'h1c

// enable bits, main register
`define BIT_MASTER       7
`define BIT_SERIAL2      6
`define BIT_WATCHDOG     5
`define BIT_SERIAL1      4
`define BIT_TIMER1       3
`define BIT_EXT_IN1      2
`define BIT_TIMER0       1
`define BIT_EXT_IN0      0
// enable bits, extension register
`define BIT_GRP_HIGH     6
`define BIT_GRP_LOW      5
`define BIT_CONVERTER    4
`define BIT_CLK_CAL      2
`define BIT_TWO_WIRE     1
`define BIT_SPI          0

// writable bits; reserved bits read zero
`define MASK_IE_EXT      8'h77
`define MASK_PRIO_D      8'hf3
`define MASK_PRIO_E      8'h03

`define RST_IE           8'h00
`define RST_PRIO         8'h00
`define RST_BUSY         4'h0

`endif

// ---- rtl/irq_prio_pkg.sv ----
// types shared by the interrupt enable and priority block
`default_nettype none
package irq_prio_pkg;

   localparam int NUM_SRC = 16;

   // query order: index 0 is asked first
   typedef enum logic [3:0] {
      SRC_EXT_IN0   = 4'h0,
      SRC_TIMER0    = 4'h1,
      SRC_EXT_IN1   = 4'h2,
      SRC_TIMER1    = 4'h3,
      SRC_SERIAL1   = 4'h4,
      SRC_WATCHDOG  = 4'h5,
      SRC_UNDERVOLT = 4'h6,
      SRC_SERIAL2   = 4'h7,
      SRC_SPI       = 4'h8,
      SRC_TWO_WIRE  = 4'h9,
      SRC_CAPTURE   = 4'ha,
      SRC_PULSE_W   = 4'hb,
      SRC_CLK_CAL   = 4'hc,
      SRC_CONVERTER = 4'hd,
      SRC_GRP_LOW   = 4'he,
      SRC_GRP_HIGH  = 4'hf
   } src_id_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

   typedef struct packed {
      logic       req;
      src_id_t    id;
      logic [1:0] level;
   } core_irq_t;

   typedef struct packed {
      logic       take;
      logic       return_from_interrupt_op;
      logic       ret;
   } core_evt_t;

   typedef struct packed {
      logic [1:0]      rsync;
      logic [7:0]      ie_main;
      logic [7:0]      ie_ext;
      logic [4:0][7:0] prio;
      logic [3:0]      busy;
      wb_rsp_t         rsp;
      core_irq_t       irq;
   } state_t;

endpackage : irq_prio_pkg
`default_nettype wire

// ---- rtl/irq_prio_ctrl.sv ----
// interrupt enable and priority registers with level arbitration
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`default_nettype none
`include "irq_prio_cfg.svh"

module irq_prio_ctrl #(
   parameter int ADDR_W = 8
) (
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   input  wire irq_prio_pkg::wb_req_t  wb_in,
   output var  irq_prio_pkg::wb_rsp_t  wb_out,
   input  wire logic [15:0]            src_flag,
   input  wire irq_prio_pkg::core_evt_t core_evt,
   output var  irq_prio_pkg::core_irq_t core_irq
);

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (ADDR_W != 8)
   begin : g_chk
      $error("irq_prio_ctrl: address width must be 8");
   end

   irq_prio_pkg::state_t st_r;
   irq_prio_pkg::state_t st_nxt;

   logic        rst_ok;
   logic [15:0] en_vec;
   logic [15:0][1:0] lvl_vec;
   logic [15:0] elig;
   logic [2:0]  thr;
   logic [3:0]  busy_tmp;
   logic [31:0] rd_val;
   logic        hit;

   assign rst_ok = st_r.rsync[1];
   assign wb_out = st_r.rsp;
   assign core_irq = st_r.irq;

   // index of the lowest level at which a new request may still enter
   function automatic logic [2:0] entry_level(input logic [3:0] b);
      logic [2:0] r;
      r = 3'h0;
      for (int k = 0; k < 4; k++)
      begin
         if (b[k])
         begin
            r = 3'(k + 1);
         end
      end
      return r;
   endfunction : entry_level

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rsync = {st_r.rsync[0], 1'b1};

      // lvd, capture array and pulse width have no gate here
      en_vec = '1;
      en_vec[irq_prio_pkg::SRC_EXT_IN0]  = st_r.ie_main[`BIT_EXT_IN0];
      en_vec[irq_prio_pkg::SRC_TIMER0]   = st_r.ie_main[`BIT_TIMER0];
      en_vec[irq_prio_pkg::SRC_EXT_IN1]  = st_r.ie_main[`BIT_EXT_IN1];
      en_vec[irq_prio_pkg::SRC_TIMER1]   = st_r.ie_main[`BIT_TIMER1];
      en_vec[irq_prio_pkg::SRC_SERIAL1]  = st_r.ie_main[`BIT_SERIAL1];
      en_vec[irq_prio_pkg::SRC_WATCHDOG] = st_r.ie_main[`BIT_WATCHDOG];
      en_vec[irq_prio_pkg::SRC_SERIAL2]  = st_r.ie_main[`BIT_SERIAL2];
      en_vec[irq_prio_pkg::SRC_SPI]      = st_r.ie_ext[`BIT_SPI];
      en_vec[irq_prio_pkg::SRC_TWO_WIRE] = st_r.ie_ext[`BIT_TWO_WIRE];
      en_vec[irq_prio_pkg::SRC_CLK_CAL]  = st_r.ie_ext[`BIT_CLK_CAL];
      en_vec[irq_prio_pkg::SRC_CONVERTER] =
         st_r.ie_ext[`BIT_CONVERTER];
      en_vec[irq_prio_pkg::SRC_GRP_LOW]  = st_r.ie_ext[`BIT_GRP_LOW];
      en_vec[irq_prio_pkg::SRC_GRP_HIGH] = st_r.ie_ext[`BIT_GRP_HIGH];

      lvl_vec[0]  = st_r.prio[0][1:0];
      lvl_vec[1]  = st_r.prio[0][3:2];
      lvl_vec[2]  = st_r.prio[0][5:4];
      lvl_vec[3]  = st_r.prio[0][7:6];
      lvl_vec[4]  = st_r.prio[1][1:0];
      lvl_vec[5]  = st_r.prio[1][3:2];
      lvl_vec[6]  = st_r.prio[1][5:4];
      lvl_vec[7]  = st_r.prio[1][7:6];
      lvl_vec[8]  = st_r.prio[2][1:0];
      lvl_vec[9]  = st_r.prio[2][3:2];
      lvl_vec[10] = st_r.prio[2][5:4];
      lvl_vec[11] = st_r.prio[2][7:6];
      lvl_vec[12] = st_r.prio[3][1:0];
      lvl_vec[13] = st_r.prio[3][5:4];
      lvl_vec[14] = st_r.prio[3][7:6];
      lvl_vec[15] = st_r.prio[4][1:0];

      // busy levels: return releases the top one, a take marks its level
      busy_tmp = st_r.busy;
      if (core_evt.return_from_interrupt_op)
      begin
         for (int k = 0; k < 4; k++)
         begin
            if (st_r.busy[k] && (entry_level(st_r.busy) == 3'(k + 1)))
            begin
               busy_tmp[k] = 1'b0;
            end
         end
      end
      // core_evt.ret is deliberately not looked at
      if (core_evt.take && st_r.irq.req)
      begin
         busy_tmp[st_r.irq.level] = 1'b1;
      end
      st_nxt.busy = busy_tmp;

      // arbitration against the new busy set so a taken one drops at once
      thr = entry_level(busy_tmp);
      st_nxt.irq = '0;
      for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
      begin
         elig[i] = src_flag[i] && en_vec[i]
                   && st_r.ie_main[`BIT_MASTER]
                   && ({1'b0, lvl_vec[i]} >= thr);
         // strictly greater keeps the earliest index on a tie
         if (elig[i] && (!st_nxt.irq.req
                         || lvl_vec[i] > st_nxt.irq.level))
         begin
            st_nxt.irq.req   = 1'b1;
            st_nxt.irq.id    = irq_prio_pkg::src_id_t'(4'(i));
            st_nxt.irq.level = lvl_vec[i];
         end
      end

      // register bus, one wait state, unmapped reads zero
      hit = 1'b1;
      case (wb_in.adr)
         `OFS_IE_MAIN : rd_val = {24'h0, st_r.ie_main};
         `OFS_IE_EXT  : rd_val = {24'h0, st_r.ie_ext};
         `OFS_PRIO_A  : rd_val = {24'h0, st_r.prio[0]};
         `OFS_PRIO_B  : rd_val = {24'h0, st_r.prio[1]};
         `OFS_PRIO_C  : rd_val = {24'h0, st_r.prio[2]};
         `OFS_PRIO_D  : rd_val = {24'h0, st_r.prio[3]};
         `OFS_PRIO_E  : rd_val = {24'h0, st_r.prio[4]};
         `OFS_STATUS  : rd_val = {23'h0, st_r.irq.req, st_r.irq.id,
                                  st_r.busy};
         default      :
         begin
            rd_val = 32'h0;
            hit = 1'b0;
         end
      endcase
      st_nxt.rsp.ack = 1'b0;
      // a stb still held in the ack cycle is not taken a second time
      if (wb_in.cyc && wb_in.stb && !st_r.rsp.ack)
      begin
         st_nxt.rsp.ack = 1'b1;
         st_nxt.rsp.dat = wb_in.we ? 32'h0 : rd_val;
         if (wb_in.we && wb_in.sel[0] && hit)
         begin
            case (wb_in.adr)
               `OFS_IE_MAIN : st_nxt.ie_main = wb_in.dat[7:0];
               `OFS_IE_EXT  : st_nxt.ie_ext =
                                 wb_in.dat[7:0] & `MASK_IE_EXT;
               `OFS_PRIO_A  : st_nxt.prio[0] = wb_in.dat[7:0];
               `OFS_PRIO_B  : st_nxt.prio[1] = wb_in.dat[7:0];
               `OFS_PRIO_C  : st_nxt.prio[2] = wb_in.dat[7:0];
               `OFS_PRIO_D  : st_nxt.prio[3] =
                                 wb_in.dat[7:0] & `MASK_PRIO_D;
               `OFS_PRIO_E  : st_nxt.prio[4] =
                                 wb_in.dat[7:0] & `MASK_PRIO_E;
               default      : st_nxt.rsp.dat = 32'h0;
            endcase
         end
      end

      // held in reset until the release has passed both sync stages
      if (!rst_ok)
      begin
         st_nxt = '0;
         st_nxt.rsync = {st_r.rsync[0], 1'b1};
         st_nxt.ie_main = `RST_IE;
         st_nxt.ie_ext = `RST_IE;
         st_nxt.prio = {5{`RST_PRIO}};
         st_nxt.busy = `RST_BUSY;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_ok);

   sequence s_wr(logic [7:0] a);
      wb_in.cyc && wb_in.stb && wb_in.we && wb_in.sel[0]
         && !st_r.rsp.ack && wb_in.adr == a;
   endsequence

   sequence s_taken;
      core_evt.take && st_r.irq.req && !core_evt.return_from_interrupt_op;
   endsequence

   property p_master_off;
      !st_r.ie_main[`BIT_MASTER] |=> !core_irq.req;
   endproperty
   a_master_off: assert property (p_master_off)
      else $error("request raised while master enable clear");

   for (genvar g = 0; g < 16; g++)
   begin : g_gate
      property p_gate;
         core_irq.req && core_irq.id == 4'(g)
            |-> $past(en_vec[g] && src_flag[g]);
      endproperty
      a_gate: assert property (p_gate)
         else $error("request forwarded from a gated source");

      // no eligible source may sit above the level that won
      property p_highest;
         core_irq.req
            |-> !($past(elig[g]) && $past(lvl_vec[g]) > core_irq.level);
      endproperty
      a_highest: assert property (p_highest)
         else $error("lower level request won arbitration");
   end

   property p_ext_rsvd;
      s_wr(`OFS_IE_EXT) |=> st_r.ie_ext[3] == 1'b0 && st_r.ie_ext[7] == 1'b0;
   endproperty
   a_ext_rsvd: assert property (p_ext_rsvd)
      else $error("reserved enable bit stored");

   property p_prio_a;
      logic [7:0] d;
      (s_wr(`OFS_PRIO_A), d = wb_in.dat[7:0])
         |=> st_r.prio[0] == d ##1 lvl_vec[3] == d[7:6];
   endproperty
   a_prio_a: assert property (p_prio_a)
      else $error("level register a not stored");

   property p_prio_b;
      s_wr(`OFS_PRIO_B) |=> st_r.prio[1] == $past(wb_in.dat[7:0]);
   endproperty
   a_prio_b: assert property (p_prio_b)
      else $error("level register b not stored");

   property p_prio_c;
      s_wr(`OFS_PRIO_C) |=> st_r.prio[2] == $past(wb_in.dat[7:0]);
   endproperty
   a_prio_c: assert property (p_prio_c)
      else $error("level register c not stored");

   property p_prio_d;
      s_wr(`OFS_PRIO_D) |=> st_r.prio[3][3:2] == 2'h0;
   endproperty
   a_prio_d: assert property (p_prio_d)
      else $error("reserved level bits stored");

   property p_prio_e;
      s_wr(`OFS_PRIO_E) |=> st_r.prio[4][7:2] == 6'h0;
   endproperty
   a_prio_e: assert property (p_prio_e)
      else $error("reserved level bits stored");

   property p_above_busy;
      core_irq.req |-> {1'b0, core_irq.level} >= entry_level(st_r.busy);
   endproperty
   a_above_busy: assert property (p_above_busy)
      else $error("request not above the busy level");

   property p_top_blocks;
      st_r.busy[3] && !core_evt.return_from_interrupt_op |=> !core_irq.req;
   endproperty
   a_top_blocks: assert property (p_top_blocks)
      else $error("request passed while top level busy");

   property p_take_marks;
      s_taken |=> st_r.busy[$past(core_irq.level)];
   endproperty
   a_take_marks: assert property (p_take_marks)
      else $error("taken level not marked busy");

   // source 0 is asked first, so it never loses a tie
   property p_tie_order;
      core_irq.req && core_irq.id != 4'h0
         |-> !($past(elig[0]) && $past(lvl_vec[0]) == core_irq.level);
   endproperty
   a_tie_order: assert property (p_tie_order)
      else $error("tie not resolved in query order");

   property p_plain_ret;
      core_evt.ret && !core_evt.return_from_interrupt_op && !core_evt.take
         |=> st_r.busy == $past(st_r.busy);
   endproperty
   a_plain_ret: assert property (p_plain_ret)
      else $error("plain return released a busy level");

   property p_return_from_interrupt_op_top;
      core_evt.return_from_interrupt_op && !core_evt.take && st_r.busy[3] |=> !st_r.busy[3];
   endproperty
   a_return_from_interrupt_op_top: assert property (p_return_from_interrupt_op_top)
      else $error("interrupt return left the top level busy");

endmodule : irq_prio_ctrl
`default_nettype wire

// ---- rtl/irq_prio_unused.sv ----
// no logic: the whole block lives in irq_prio_ctrl.sv

// ---- tb/irq_core_model.sv ----
// core-side partner: takes offered requests and issues returns
`default_nettype none
module irq_core_model
(
   input  wire logic                    clock,
   input  wire irq_prio_pkg::core_irq_t core_irq,
   input  wire logic                    take_en,
   input  wire logic                    return_from_interrupt_op_cmd,
   input  wire logic                    ret_cmd,
   output var  irq_prio_pkg::core_evt_t core_evt
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // event pulses
   // ****************
   // no second take before req has caught up with the new busy level
   always @(posedge clock)
   begin
      core_evt.take <= core_irq.req & take_en & ~core_evt.take;
      core_evt.return_from_interrupt_op <= return_from_interrupt_op_cmd;
      core_evt.ret  <= ret_cmd;
   end
endmodule : irq_core_model
`default_nettype wire

// ---- tb/interrupt_enable_priority_regs_test.sv ----
// self-checking bench for the interrupt enable and priority block
`default_nettype none
`include "irq_prio_cfg.svh"
module interrupt_enable_priority_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    clock;
   logic                    arst_n;
   irq_prio_pkg::wb_req_t   wb_in;
   irq_prio_pkg::wb_rsp_t   wb_out;
   logic [15:0]             src_flag;
   irq_prio_pkg::core_evt_t core_evt;
   irq_prio_pkg::core_irq_t core_irq;
   logic                    take_en;
   logic                    return_from_interrupt_op_cmd;
   logic                    ret_cmd;
   logic [31:0]             q;
   logic [7:0]              g;
   logic [7:0]              a;
   logic [1:0]              lv;
   int                      num_errors;
   int                      compares;
   int                      k;
   // offset and read-back after writing all ones
   localparam logic [15:0] REG_TAB [8] = '{
      {`OFS_IE_MAIN, 8'hff}, {`OFS_IE_EXT, 8'h77},
      {`OFS_PRIO_A, 8'hff}, {`OFS_PRIO_B, 8'hff}, {`OFS_PRIO_C, 8'hff},
      {`OFS_PRIO_D, 8'hf3}, {`OFS_PRIO_E, 8'h03}, {8'h20, 8'h00}};
   // source index, extension register, bit
   localparam logic [7:0] GATE_TAB [13] = '{
      8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h76,
      8'h88, 8'h99, 8'hca, 8'hdc, 8'hed, 8'hfe};
   // field slot of each source: register a..e times four plus field
   localparam int POS [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11,
      12, 14, 15, 16};

   irq_prio_ctrl #(.ADDR_W(8)) dut
   (
      .clock    (clock),
      .arst_n   (arst_n),
      .wb_in    (wb_in),
      .wb_out   (wb_out),
      .src_flag (src_flag),
      .core_evt (core_evt),
      .core_irq (core_irq)
   );
   irq_core_model partner
   (
      .clock    (clock),
      .core_irq (core_irq),
      .take_en  (take_en),
      .return_from_interrupt_op_cmd (return_from_interrupt_op_cmd),
      .ret_cmd  (ret_cmd),
      .core_evt (core_evt)
   );

   // ****************
   // tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // called just after a rising edge; returns just after one
   task automatic xfer(input logic w, input logic [7:0] ad,
                       input logic [7:0] d);
      // no limit of its own: the watchdog ends a hung wait
      wb_in <= {1'b1, 1'b1, w, ad, 4'hf, 24'h0, d};
      do
      begin
         @(posedge clock);
      end
      while (wb_out.ack !== 1'b1);
      q = wb_out.dat;
      wb_in <= '0;
      @(posedge clock);
   endtask : xfer

   task automatic irq_is(input logic [6:0] e);
      repeat (3) @(posedge clock);
      check({25'h0, core_irq}, {25'h0, e});
   endtask : irq_is

   task automatic busy_is(input logic [3:0] e);
      repeat (3) @(posedge clock);
      xfer(1'b0, `OFS_STATUS, 8'h00);
      check(q & 32'hf, {28'h0, e});
   endtask : busy_is

   task automatic evt(input logic r);
      if (r)
         return_from_interrupt_op_cmd <= 1'b1;
      else
         ret_cmd <= 1'b1;
      @(posedge clock);
      return_from_interrupt_op_cmd <= 1'b0;
      ret_cmd  <= 1'b0;
      @(posedge clock);
   endtask : evt

   task automatic final_report;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   // ****************
   // stimulus
   // ****************
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      num_errors++;
      final_report();
   end

   initial
   begin
      arst_n = 1'b0;
      wb_in = '0;
      src_flag = '0;
      take_en = 1'b0;
      return_from_interrupt_op_cmd = 1'b0;
      ret_cmd = 1'b0;
      num_errors = 0;
      compares = 0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (k = 0; k < 8; k++)
      begin
         xfer(1'b0, REG_TAB[k][15:8], 8'h00);
         check(q, 32'h0);
         xfer(1'b1, REG_TAB[k][15:8], 8'hff);
         xfer(1'b0, REG_TAB[k][15:8], 8'h00);
         check(q, {24'h0, REG_TAB[k][7:0]});
         xfer(1'b1, REG_TAB[k][15:8], 8'h00);
      end
      for (k = 0; k < 13; k++)
      begin
         g = GATE_TAB[k];
         src_flag <= 16'h1 << g[7:4];
         xfer(1'b1, `OFS_IE_MAIN, 8'h80);
         irq_is(7'h00);
         if (g[3])
            xfer(1'b1, `OFS_IE_EXT, 8'h1 << g[2:0]);
         else
            xfer(1'b1, `OFS_IE_MAIN, 8'h80 | (8'h1 << g[2:0]));
         irq_is({1'b1, g[7:4], 2'b00});
         xfer(1'b1, `OFS_IE_MAIN, g[3] ? 8'h00 : 8'h1 << g[2:0]);
         irq_is(7'h00);
         xfer(1'b1, `OFS_IE_EXT, 8'h00);
      end
      xfer(1'b1, `OFS_IE_MAIN, 8'hff);
      xfer(1'b1, `OFS_IE_EXT, 8'h77);
      for (k = 0; k < 16; k++)
      begin
         lv = 2'(k % 3 + 1);
         a = 8'(8 + 4 * (POS[k] / 4));
         src_flag <= 16'h1 | (16'h1 << k);
         xfer(1'b1, a, 8'(lv) << (2 * (POS[k] % 4)));
         irq_is({1'b1, 4'(k), lv});
         xfer(1'b1, a, 8'h00);
      end
      src_flag <= 16'hffff;
      irq_is(7'h40);
      src_flag <= 16'hfffe;
      irq_is(7'h44);
      src_flag <= 16'h0000;
      xfer(1'b1, `OFS_PRIO_A, 8'h09);
      take_en <= 1'b1;
      src_flag <= 16'h0001;
      busy_is(4'h2);
      src_flag <= 16'h0003;
      busy_is(4'h6);
      take_en <= 1'b0;
      irq_is(7'h00);
      evt(1'b0);
      busy_is(4'h6);
      irq_is(7'h00);
      evt(1'b1);
      irq_is(7'h46);
      busy_is(4'h2);
      evt(1'b1);
      busy_is(4'h0);
      src_flag <= 16'h000b;
      xfer(1'b1, `OFS_PRIO_A, 8'hcd);
      irq_is(7'h47);
      take_en <= 1'b1;
      busy_is(4'h8);
      take_en <= 1'b0;
      irq_is(7'h00);
      evt(1'b1);
      irq_is(7'h47);
      final_report();
   end
endmodule : interrupt_enable_priority_regs_test
`default_nettype wire
